// [pssc_core_regs.sv]
// Page select stack and core registers of the processor.
// Assumes the core sequencer pulses entry and return for one cycle each.
`timescale 1ns/10ps
`default_nettype none
module pssc_core_regs (
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  reset_i,
    // Interrupt sequencing from the core
    input  wire logic                  irq_entry_i,
    input  wire logic [7:0]            irq_page_i,
    input  wire logic                  interrupt_return_op_i,
    // Core stack push and pop requests
    input  wire logic                  sp_push_i,
    input  wire logic                  sp_pop_i,
    // Software register access
    input  wire pssc_pkg::pssc_access_t access_i,
    // Accumulator bit access
    input  wire logic                  acc_bit_we_i,
    input  wire logic [2:0]            acc_bit_sel_i,
    input  wire logic                  acc_bit_val_i,
    // Read answer
    output logic [7:0]                 rdata_o,
    output logic                       rvalid_o,
    // Register values for the core
    output logic [7:0]                 active_page_sel_o,
    output logic [15:0]                indirect_pointer_word_o,
    output logic [7:0]                 stack_pointer_o,
    output logic [7:0]                 arith_work_reg_o,
    output logic                       auto_page_switch_en_o
);

    pssc_pkg::pssc_stack_t stack;
    pssc_pkg::pssc_op_t    op;
    logic [2:0]            level_we;
    logic [7:0]            stack_pointer;
    logic [7:0]            next_stack_pointer;
    logic [7:0]            data_pointer_low;
    logic [7:0]            next_data_pointer_low;
    logic [7:0]            data_pointer_high;
    logic [7:0]            next_data_pointer_high;
    logic [7:0]            arith_work_reg;
    logic [7:0]            next_arith_work_reg;
    logic                  auto_page_switch_en;
    logic                  next_auto_page_switch_en;
    logic                  on_ctl_page;
    logic                  rd_hit;
    logic [7:0]            rd_value;

    // Software write hit for an address
    function automatic logic wr_hit(input pssc_pkg::pssc_access_t a,
                                    input logic [7:0] addr);
        wr_hit = a.wr && (a.addr == addr);
    endfunction

    // Paged registers need the control page selected
    assign on_ctl_page = (stack.active == pssc_pkg::CONTROL_PAGE);

    // Stack operation choice
    always_comb begin
        op = pssc_pkg::PSSC_HOLD;
        if (auto_page_switch_en) begin
            if (irq_entry_i) begin
                op = pssc_pkg::PSSC_PUSH;
            end else if (interrupt_return_op_i) begin
                op = pssc_pkg::PSSC_POP;
            end
        end
        level_we[2] = wr_hit(access_i, pssc_pkg::ACTIVE_PAGE_SEL_ADDR);
        level_we[1] = on_ctl_page && wr_hit(access_i, pssc_pkg::PAGE_STACK_MIDDLE_ADDR);
        level_we[0] = on_ctl_page && wr_hit(access_i, pssc_pkg::PAGE_STACK_BOTTOM_ADDR);
    end

    pssc_page_stack u_stack (
        .clk_i        (clk_i),
        .reset_i      (reset_i),
        .op_i         (op),
        .entry_page_i (irq_page_i),
        .level_we_i   (level_we),
        .wdata_i      (access_i.wdata),
        .stack_o      (stack)
    );

    // Core register next values; push and pop win over a stack pointer write, a software write wins over an accumulator bit write
    always_comb begin
        next_stack_pointer       = stack_pointer;
        next_data_pointer_low    = data_pointer_low;
        next_data_pointer_high   = data_pointer_high;
        next_arith_work_reg      = arith_work_reg;
        next_auto_page_switch_en = auto_page_switch_en;
        if (wr_hit(access_i, pssc_pkg::STACK_POINTER_ADDR)) begin
            next_stack_pointer = access_i.wdata;
        end
        if (sp_push_i) begin
            next_stack_pointer = stack_pointer + 8'h01;
        end else if (sp_pop_i) begin
            next_stack_pointer = stack_pointer - 8'h01;
        end
        if (wr_hit(access_i, pssc_pkg::DATA_POINTER_LOW_ADDR)) begin
            next_data_pointer_low = access_i.wdata;
        end
        if (wr_hit(access_i, pssc_pkg::DATA_POINTER_HIGH_ADDR)) begin
            next_data_pointer_high = access_i.wdata;
        end
        if (wr_hit(access_i, pssc_pkg::ARITH_WORK_REG_ADDR)) begin
            next_arith_work_reg = access_i.wdata;
        end else if (acc_bit_we_i) begin
            next_arith_work_reg[acc_bit_sel_i] = acc_bit_val_i;
        end
        if (on_ctl_page && wr_hit(access_i, pssc_pkg::PAGE_CONTROL_REG_ADDR)) begin
            next_auto_page_switch_en = access_i.wdata[pssc_pkg::AUTO_PAGE_SWITCH_EN_BIT];
        end
    end

    // Register core state
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            stack_pointer       <= pssc_pkg::STACK_POINTER_RST;
            data_pointer_low    <= pssc_pkg::DATA_POINTER_RST;
            data_pointer_high   <= pssc_pkg::DATA_POINTER_RST;
            arith_work_reg      <= pssc_pkg::ARITH_WORK_REG_RST;
            auto_page_switch_en <= pssc_pkg::AUTO_PAGE_SWITCH_RST;
        end else begin
            stack_pointer       <= next_stack_pointer;
            data_pointer_low    <= next_data_pointer_low;
            data_pointer_high   <= next_data_pointer_high;
            arith_work_reg      <= next_arith_work_reg;
            auto_page_switch_en <= next_auto_page_switch_en;
        end
    end

    // Read select; core registers ignore the page, paged ones need it
    always_comb begin
        rd_hit   = 1'b1;
        rd_value = 8'h00;
        if (access_i.addr == pssc_pkg::STACK_POINTER_ADDR) begin
            rd_value = stack_pointer;
        end else if (access_i.addr == pssc_pkg::DATA_POINTER_LOW_ADDR) begin
            rd_value = data_pointer_low;
        end else if (access_i.addr == pssc_pkg::DATA_POINTER_HIGH_ADDR) begin
            rd_value = data_pointer_high;
        end else if (access_i.addr == pssc_pkg::ARITH_WORK_REG_ADDR) begin
            rd_value = arith_work_reg;
        end else if (access_i.addr == pssc_pkg::ACTIVE_PAGE_SEL_ADDR) begin
            rd_value = stack.active;
        end else if (on_ctl_page && access_i.addr == pssc_pkg::PAGE_STACK_MIDDLE_ADDR) begin
            rd_value = stack.middle;
        end else if (on_ctl_page && access_i.addr == pssc_pkg::PAGE_STACK_BOTTOM_ADDR) begin
            rd_value = stack.bottom;
        end else if (on_ctl_page && access_i.addr == pssc_pkg::PAGE_CONTROL_REG_ADDR) begin
            rd_value = {7'h00, auto_page_switch_en}; // Reserved bits read zero
        end else begin
            rd_hit = 1'b0;
        end
    end

    pssc_read_mux u_rd (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .rd_i     (access_i.rd),
        .hit_i    (rd_hit),
        .value_i  (rd_value),
        .rdata_o  (rdata_o),
        .rvalid_o (rvalid_o)
    );

    // Register-backed outputs
    assign active_page_sel_o       = stack.active;
    assign indirect_pointer_word_o = {data_pointer_high, data_pointer_low};
    assign stack_pointer_o         = stack_pointer;
    assign arith_work_reg_o        = arith_work_reg;
    assign auto_page_switch_en_o   = auto_page_switch_en;

endmodule
`default_nettype wire

// [pssc_pkg.sv]
// Package for the page select stack and core register bank.
// Shared by the bank top, the page stack, the checker and the bench; no imports used.
package pssc_pkg;

    // Register addresses in the special register space
    localparam logic [7:0] STACK_POINTER_ADDR     = 8'h81;
    localparam logic [7:0] DATA_POINTER_LOW_ADDR  = 8'h82;
    localparam logic [7:0] DATA_POINTER_HIGH_ADDR = 8'h83;
    localparam logic [7:0] ARITH_WORK_REG_ADDR    = 8'he0;
    localparam logic [7:0] ACTIVE_PAGE_SEL_ADDR   = 8'ha7;
    localparam logic [7:0] PAGE_CONTROL_REG_ADDR  = 8'ha6;
    localparam logic [7:0] PAGE_STACK_MIDDLE_ADDR = 8'h85;
    localparam logic [7:0] PAGE_STACK_BOTTOM_ADDR = 8'h86;

    // Page that holds the control and stack registers
    localparam logic [7:0] CONTROL_PAGE           = 8'h0f;

    // Field positions
    localparam int         AUTO_PAGE_SWITCH_EN_BIT = 0;

    // Reset values
    localparam logic [7:0] STACK_POINTER_RST      = 8'h07;
    localparam logic [7:0] DATA_POINTER_RST       = 8'h00;
    localparam logic [7:0] ARITH_WORK_REG_RST     = 8'h00;
    localparam logic [7:0] ACTIVE_PAGE_SEL_RST    = 8'h00;
    localparam logic [7:0] PAGE_STACK_RST         = 8'h00;
    localparam logic       AUTO_PAGE_SWITCH_RST   = 1'b1;

    // Page stack contents
    typedef struct packed {
        logic [7:0] active;
        logic [7:0] middle;
        logic [7:0] bottom;
    } pssc_stack_t;

    // Software register access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pssc_access_t;

    // Stack operation requested this cycle
    typedef enum logic [1:0] {
        PSSC_HOLD = 2'b00,
        PSSC_PUSH = 2'b01,
        PSSC_POP  = 2'b11,
        PSSC_LOAD = 2'b10
    } pssc_op_t;

endpackage

// [pssc_page_stack.sv]
// Three-level page selection stack with push, pop and software writes.
// Assumes the caller never asks for push and pop in the same cycle.
`timescale 1ns/10ps
`default_nettype none
module pssc_page_stack (
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 reset_i,
    // Stack control
    input  wire pssc_pkg::pssc_op_t   op_i,
    input  wire logic [7:0]           entry_page_i,
    input  wire logic [2:0]           level_we_i,
    input  wire logic [7:0]           wdata_i,
    // Stack contents
    output var   pssc_pkg::pssc_stack_t stack_o
);

    pssc_pkg::pssc_stack_t stack;
    pssc_pkg::pssc_stack_t next_stack;

    // Shift on push or pop, otherwise store software writes
    always_comb begin
        next_stack = stack;
        case (op_i)
            pssc_pkg::PSSC_PUSH: begin
                next_stack.bottom = stack.middle;
                next_stack.middle = stack.active;
                next_stack.active = entry_page_i;
            end
            pssc_pkg::PSSC_POP: begin
                next_stack.active = stack.middle;
                next_stack.middle = stack.bottom;
            end
            default: begin
                // Plain stores, never a shift
                if (level_we_i[2]) next_stack.active = wdata_i;
                if (level_we_i[1]) next_stack.middle = wdata_i;
                if (level_we_i[0]) next_stack.bottom = wdata_i;
            end
        endcase
    end

    // Register the stack
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            stack.active <= pssc_pkg::ACTIVE_PAGE_SEL_RST;
            stack.middle <= pssc_pkg::PAGE_STACK_RST;
            stack.bottom <= pssc_pkg::PAGE_STACK_RST;
        end else begin
            stack <= next_stack;
        end
    end

    assign stack_o = stack;

endmodule
`default_nettype wire

// [pssc_read_mux.sv]
// Registered read data for the bank.
// Assumes the select inputs are stable in the read cycle.
`timescale 1ns/10ps
`default_nettype none
module pssc_read_mux (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    // Selected value
    input  wire logic       rd_i,
    input  wire logic       hit_i,
    input  wire logic [7:0] value_i,
    // Read answer
    output logic [7:0]      rdata_o,
    output logic            rvalid_o
);

    logic [7:0] next_rdata;
    logic       next_rvalid;

    // Unmapped reads answer zero
    always_comb begin
        next_rvalid = rd_i;
        next_rdata  = (rd_i && hit_i) ? value_i : 8'h00;
    end

    // Register the answer
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_o  <= 8'h00;
            rvalid_o <= 1'b0;
        end else begin
            rdata_o  <= next_rdata;
            rvalid_o <= next_rvalid;
        end
    end

endmodule
`default_nettype wire

// [pssc_core_seq_model.sv]
// Model of the core interrupt sequencer: entry and return pulses.
// Assumes the bench calls its tasks from one process only.
`timescale 1ns/10ps
`default_nettype none
module pssc_core_seq_model (
    // Clock
    input  wire logic       clk_i,
    // Pulses toward the bank
    output var  logic       irq_entry_o,
    output var  logic [7:0] irq_page_o,
    output var  logic       ret_o
);
    // Idle levels from time zero
    initial begin
        irq_entry_o = 1'b0;
        irq_page_o  = 8'h00;
        ret_o       = 1'b0;
    end
    // One-cycle service pulse; stale page not left on the bus
    task automatic enter(input logic [7:0] page);
        @(posedge clk_i);
        irq_entry_o <= 1'b1;
        irq_page_o  <= page;
        @(posedge clk_i);
        irq_entry_o <= 1'b0;
        irq_page_o  <= ~page;
    endtask
    // One-cycle return pulse
    task automatic leave();
        @(posedge clk_i);
        ret_o <= 1'b1;
        @(posedge clk_i);
        ret_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [pssc_core_regs_checker.sv]
// Assertions on the ports of the page stack and core register bank.
// Assumes one clock domain with a synchronous high reset.
`timescale 1ns/10ps
`default_nettype none
module pssc_core_regs_checker (
    // Clock and reset
    input wire logic                   clk_i,
    input wire logic                   reset_i,
    // Watched inputs
    input wire logic                   irq_entry_i,
    input wire logic [7:0]             irq_page_i,
    input wire logic                   interrupt_return_op_i,
    input wire logic                   sp_push_i,
    input wire pssc_pkg::pssc_access_t access_i,
    input wire logic                   acc_bit_we_i,
    input wire logic [2:0]             acc_bit_sel_i,
    input wire logic                   acc_bit_val_i,
    // Watched outputs
    input wire logic [7:0]             rdata_o,
    input wire logic                   rvalid_o,
    input wire logic [7:0]             active_page_sel_o,
    input wire logic [15:0]            indirect_pointer_word_o,
    input wire logic [7:0]             stack_pointer_o,
    input wire logic [7:0]             arith_work_reg_o,
    input wire logic                   auto_page_switch_en_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // Byte writes; only the accumulator write overrides the other update
    logic wr_pg, wr_sp, wr_acc;
    assign wr_pg  = access_i.wr && access_i.addr == pssc_pkg::ACTIVE_PAGE_SEL_ADDR;
    assign wr_sp  = access_i.wr && access_i.addr == pssc_pkg::STACK_POINTER_ADDR;
    assign wr_acc = access_i.wr && access_i.addr == pssc_pkg::ARITH_WORK_REG_ADDR;
    a_entry_load_page: assert property (irq_entry_i && auto_page_switch_en_o
        |=> active_page_sel_o == $past(irq_page_i)) else $error("entry page not loaded");
    a_off_page_hold: assert property ((irq_entry_i || interrupt_return_op_i)
        && !auto_page_switch_en_o && !wr_pg |=> $stable(active_page_sel_o))
        else $error("page moved while switching off");
    a_enable_reset: assert property ($fell(reset_i) |-> auto_page_switch_en_o)
        else $error("switch enable not set after reset");
    a_core_reset: assert property ($fell(reset_i) |-> stack_pointer_o == 8'h07
        && indirect_pointer_word_o == 16'h0000 && arith_work_reg_o == 8'h00)
        else $error("core register reset value wrong");
    a_sp_push_inc: assert property (sp_push_i && !wr_sp
        |=> stack_pointer_o == $past(stack_pointer_o) + 8'h01) else $error("sp not incremented");
    a_read_pulse: assert property (rvalid_o == $past(access_i.rd))
        else $error("read valid not one cycle after read");
    a_core_any_page: assert property (access_i.rd
        && access_i.addr == pssc_pkg::STACK_POINTER_ADDR
        |=> rdata_o == $past(stack_pointer_o)) else $error("sp read data wrong");
    a_page_write: assert property (wr_pg && !irq_entry_i && !interrupt_return_op_i
        |=> active_page_sel_o == $past(access_i.wdata)) else $error("page write not applied");
    a_acc_bit_set: assert property (acc_bit_we_i && !wr_acc
        |=> arith_work_reg_o[$past(acc_bit_sel_i)] == $past(acc_bit_val_i))
        else $error("accumulator bit write lost");
    // Main scenarios reached
    c_entry: cover property (irq_entry_i && auto_page_switch_en_o);
    c_return: cover property (interrupt_return_op_i && auto_page_switch_en_o);
    c_off_entry: cover property (irq_entry_i && !auto_page_switch_en_o);
endmodule
bind pssc_core_regs pssc_core_regs_checker i_pssc_core_regs_checker (.clk_i(clk_i),
    .reset_i(reset_i), .irq_entry_i(irq_entry_i), .irq_page_i(irq_page_i),
    .interrupt_return_op_i(interrupt_return_op_i), .sp_push_i(sp_push_i),
    .access_i(access_i), .acc_bit_we_i(acc_bit_we_i), .acc_bit_sel_i(acc_bit_sel_i),
    .acc_bit_val_i(acc_bit_val_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .active_page_sel_o(active_page_sel_o), .indirect_pointer_word_o(indirect_pointer_word_o),
    .stack_pointer_o(stack_pointer_o), .arith_work_reg_o(arith_work_reg_o),
    .auto_page_switch_en_o(auto_page_switch_en_o));
`default_nettype wire

// [pssc_core_regs_tb.sv]
// Self-checking bench for the page stack and core register bank.
// Assumes the checker is bound in from its own file.
`timescale 1ns/10ps
`default_nettype none
module pssc_core_regs_tb;
    logic                  clk_i = 1'b0, reset_i = 1'b1, sp_push_i = 1'b0, sp_pop_i = 1'b0;
    logic                  acc_bit_we_i = 1'b0, acc_bit_val_i = 1'b0, irq_entry, ret;
    logic                  rvalid_o, auto_page_switch_en_o, bot_ok = 1'b1;
    logic [2:0]            acc_bit_sel_i = 3'h0, b;
    logic [7:0]            irq_page, rdata_o, v, got;
    logic [15:0]           indirect_pointer_word_o;
    pssc_pkg::pssc_access_t access_i = '0;
    pssc_pkg::pssc_stack_t exp_stk = '0;
    int                    mismatches = 0, n_checks = 0, cycles = 0;
    pssc_core_regs i_pssc_core_regs (.clk_i(clk_i), .reset_i(reset_i), .irq_entry_i(irq_entry),
        .irq_page_i(irq_page), .interrupt_return_op_i(ret), .sp_push_i(sp_push_i),
        .sp_pop_i(sp_pop_i), .access_i(access_i), .acc_bit_we_i(acc_bit_we_i),
        .acc_bit_sel_i(acc_bit_sel_i), .acc_bit_val_i(acc_bit_val_i), .rdata_o(rdata_o),
        .rvalid_o(rvalid_o), .active_page_sel_o(), .indirect_pointer_word_o(indirect_pointer_word_o),
        .stack_pointer_o(), .arith_work_reg_o(), .auto_page_switch_en_o(auto_page_switch_en_o));
    pssc_core_seq_model i_pssc_core_seq_model (.clk_i(clk_i), .irq_entry_o(irq_entry),
        .irq_page_o(irq_page), .ret_o(ret));
    // Clock and hang guard; the run needs well under 3000 cycles
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches = mismatches + 1;
            complete_run();
        end
    end
    // Compare and count
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One software access; read answer sampled after the taking edge
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
        @(posedge clk_i);
        access_i <= {wr, ~wr, addr, wd};
        @(posedge clk_i);
        access_i <= '0;
        #1 got = rdata_o;
        check("rvalid", rvalid_o, !wr);
    endtask
    task automatic rd(input string name, input logic [7:0] addr, input logic [7:0] exp);
        access(1'b0, addr, 8'h00);
        check(name, got, exp);
    endtask
    // Expected stack after push and pop
    function automatic pssc_pkg::pssc_stack_t push(pssc_pkg::pssc_stack_t s, logic [7:0] p);
        return '{active: p, middle: s.active, bottom: s.middle};
    endfunction
    function automatic pssc_pkg::pssc_stack_t pop(pssc_pkg::pssc_stack_t s);
        return '{active: s.middle, middle: s.bottom, bottom: s.bottom};
    endfunction
    // Compare active and middle, and bottom unless a return cleared bot_ok, leaving page 0x0f and a fresh bottom value
    task automatic check_stack();
        #1 check("active", i_pssc_core_regs.active_page_sel_o, exp_stk.active);
        access(1'b1, pssc_pkg::ACTIVE_PAGE_SEL_ADDR, 8'h0f);
        rd("middle", pssc_pkg::PAGE_STACK_MIDDLE_ADDR, exp_stk.middle);
        if (bot_ok) rd("bottom", pssc_pkg::PAGE_STACK_BOTTOM_ADDR, exp_stk.bottom);
        exp_stk.active = 8'h0f;
        exp_stk.bottom = 8'($urandom);
        access(1'b1, pssc_pkg::PAGE_STACK_BOTTOM_ADDR, exp_stk.bottom);
        bot_ok = 1'b1;
    endtask
    // Verdict, reached from the main sequence or the hang guard
    task automatic complete_run();
        $display("Checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        void'($urandom(67169));
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
        rd("sp", pssc_pkg::STACK_POINTER_ADDR, 8'h07);
        rd("dpl", pssc_pkg::DATA_POINTER_LOW_ADDR, 8'h00);
        rd("dph", pssc_pkg::DATA_POINTER_HIGH_ADDR, 8'h00);
        rd("acc", pssc_pkg::ARITH_WORK_REG_ADDR, 8'h00);
        check_stack();
        rd("control", pssc_pkg::PAGE_CONTROL_REG_ADDR, 8'h01);
        $display("Test reset values done");
        // Random nesting, returns and software edits of the middle level
        for (int i = 0; i < 60; i++) begin
            v = 8'($urandom);
            case ($urandom % 4)
                0, 1: begin
                    i_pssc_core_seq_model.enter(v);
                    exp_stk = push(exp_stk, v);
                end
                2: begin
                    i_pssc_core_seq_model.leave();
                    exp_stk = pop(exp_stk);
                    bot_ok = 1'b0;
                end
                default: begin
                    access(1'b1, pssc_pkg::PAGE_STACK_MIDDLE_ADDR, v);
                    exp_stk.middle = v;
                end
            endcase
            check_stack();
        end
        $display("Test page stack done");
        // Switching off: entry and return leave every level alone
        access(1'b1, pssc_pkg::PAGE_CONTROL_REG_ADDR, 8'h00);
        i_pssc_core_seq_model.enter(8'h3c);
        i_pssc_core_seq_model.leave();
        check_stack();
        access(1'b1, pssc_pkg::PAGE_CONTROL_REG_ADDR, 8'h01);
        $display("Test switching off done");
        // Core registers from page 0x00, pushes and an accumulator bit write
        access(1'b1, pssc_pkg::ACTIVE_PAGE_SEL_ADDR, 8'h00);
        v = 8'($urandom);
        access(1'b1, pssc_pkg::DATA_POINTER_LOW_ADDR, v);
        access(1'b1, pssc_pkg::DATA_POINTER_HIGH_ADDR, ~v);
        check("pointer", indirect_pointer_word_o, {~v, v});
        access(1'b1, pssc_pkg::STACK_POINTER_ADDR, v);
        // Pulses launched on an edge, three pushes then one pop
        @(posedge clk_i);
        sp_push_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        sp_push_i <= 1'b0;
        rd("sp", pssc_pkg::STACK_POINTER_ADDR, v + 8'h03);
        @(posedge clk_i);
        sp_pop_i <= 1'b1;
        @(posedge clk_i);
        sp_pop_i <= 1'b0;
        rd("sp pop", pssc_pkg::STACK_POINTER_ADDR, v + 8'h02);
        access(1'b1, pssc_pkg::ARITH_WORK_REG_ADDR, v);
        @(posedge clk_i);
        b = 3'($urandom);
        acc_bit_sel_i <= b;
        acc_bit_val_i <= ~v[b];
        acc_bit_we_i <= 1'b1;
        @(posedge clk_i);
        acc_bit_we_i <= 1'b0;
        rd("acc", pssc_pkg::ARITH_WORK_REG_ADDR, v ^ (8'h01 << b));
        rd("unmapped", 8'h90, 8'h00);
        $display("Test core registers done");
        complete_run();
    end
endmodule
`default_nettype wire
